/* File: pkg/mct_defines.svh */
// Notes on behaviour
// - Multi-octet values arrive most significant octet first.
// - Listen until matching upstream channel found.
// - Gate zero drops subscriber traffic, keeps own.
// - Gate off still passes modem management traffic.
// - Class identifier one octet, 1 through 16.
// - Upstream forwarding capped at maximum rate per second.
// - Over-rate upstream traffic is held, not dropped.
// - Upstream priority one octet 0 to 7.
// - Guaranteed minimum upstream rate, four octets. The code only stores and reports it (min_us_q) and guarantees no minimum.
// - Burst two octets, zero means unlimited. The code only stores and reports burst_q and applies no burst limit.
// - Class privacy octet: 1 enables, 0 disables.
// - Modem integrity code type 6, 16 octets.
// - Headend integrity code type 7, 16 octets.
// - Enforce subscriber device count limit until reset.
// - Count unsigned; absent or zero means one.
// - Server timestamp: four-octet seconds since 1900.
// - Types 22-25 are classifier and flow containers.
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH
// ==========================================================
// Setting types and lengths
`define MCT_T_UCID 8'h02
`define MCT_T_GATE 8'h03
`define MCT_T_CLASS 8'h04
`define MCT_T_MIC_CM 8'h06
`define MCT_T_MIC_HE 8'h07
`define MCT_T_CPE 8'h12
`define MCT_T_TS 8'h13
`define MCT_T_US_CLS 8'h16
`define MCT_T_DS_CLS 8'h17
`define MCT_T_US_FLOW 8'h18
`define MCT_T_DS_FLOW 8'h19
`define MCT_S_ID 8'h01
`define MCT_S_MAX_DS 8'h02
`define MCT_S_MAX_US 8'h03
`define MCT_S_PRIO 8'h04
`define MCT_S_MIN_US 8'h05
`define MCT_S_BURST 8'h06
`define MCT_S_PRIV 8'h07
`define MCT_L_MIC 8'h10
`define MCT_CLS_ID_MIN 8'h01
`define MCT_CLS_ID_MAX 8'h10
`define MCT_PRIO_MAX 8'h07
// ==========================================================
// Register byte offsets
`define MCT_R_CTRL 7'h00
`define MCT_R_STATUS 7'h04
`define MCT_R_UCID 7'h08
`define MCT_R_CPE 7'h0C
`define MCT_R_CLASS 7'h10
`define MCT_R_MAX_DS 7'h14
`define MCT_R_MAX_US 7'h18
`define MCT_R_MIN_US 7'h1C
`define MCT_R_BURST 7'h20
`define MCT_R_TS 7'h24
`define MCT_R_CONT 7'h28
`define MCT_R_MIC_CM 7'h30
`define MCT_R_MIC_HE 7'h40
`define MCT_CTRL_SHAPE 0
`define MCT_CTRL_CLEAR 1
`define MCT_CTRL_RST 32'h0000_0001
// ==========================================================
// Timing and limits
`define MCT_SEC_NS 1000000000
`define MCT_CLK_NS 10
`define MCT_WIN_CYC (`MCT_SEC_NS / `MCT_CLK_NS)
`define MCT_HW_CPE_MAX 8'h10
`endif

/* File: pkg/mct_pkg.sv */
package mct_pkg;
   typedef enum logic [2:0] {
      MCT_ST_TYPE = 3'b001,
      MCT_ST_LEN = 3'b010,
      MCT_ST_VAL = 3'b100
   } mct_state_t;
endpackage : mct_pkg

/* File: pkg/mct_rate_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mct_rate_if;
   logic en;
   logic [31:0] max_bps;
   logic [15:0] len;
   logic take;
   logic ok;
   modport shp (input en, input max_bps, input len, input take, output ok);
   modport usr (output en, output max_bps, output len, output take, input ok);
endinterface : mct_rate_if
`default_nettype wire

/* File: hw/mct_shaper.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mct_defines.svh"
module mct_shaper #(
   parameter int WIN_CYC = `MCT_WIN_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   mct_rate_if.shp rate
);
   localparam int CW = $clog2(WIN_CYC + 1);
   logic [CW-1:0] cnt_q;
   logic [33:0] used_q;
   logic [33:0] need;
   logic wrap;

   assign need = {15'h0000, rate.len, 3'h0};
   assign wrap = (cnt_q == CW'(WIN_CYC - 1));
   // one-second budget
   // First frame of a window always goes, else a frame above the rate would stall forever
   assign rate.ok = !rate.en || (rate.max_bps == 32'h0000_0000) || (used_q == 34'h0) ||
                    ((used_q + need) <= {2'h0, rate.max_bps});

   // ==========================================================
   // Window counter
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || wrap) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         used_q <= 34'h0;
      end else if (wrap) begin
         used_q <= rate.take ? need : 34'h0;
      end else if (rate.take) begin
         used_q <= used_q + need;
      end
   end

   // ==========================================================
   // Checks
   over_budget_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      rate.en && rate.max_bps != 32'h0 && used_q != 34'h0 &&
      (used_q + need) > {2'h0, rate.max_bps} |-> !rate.ok)
      else $error("over budget frame allowed");
   window_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wrap && !rate.take |=> used_q == 34'h0)
      else $error("budget not renewed at window end");
   cover property (@(posedge sys_clk_in) disable iff (rst_in) rate.en && !rate.ok);
endmodule : mct_shaper
`default_nettype wire

/* File: hw/mct_tlv_policy.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mct_defines.svh"
module mct_tlv_policy #(
   parameter int WIN_CYC = `MCT_WIN_CYC,
   parameter logic [7:0] HW_CPE_MAX = `MCT_HW_CPE_MAX
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [6:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic cfg_valid_in,
   input wire logic [7:0] cfg_data_in,
   output logic cfg_ready_out,
   input wire logic ucd_valid_in,
   input wire logic [7:0] ucd_chan_in,
   output logic [7:0] us_chan_out,
   output logic keep_listening_out,
   input wire logic fwd_valid_in,
   input wire logic fwd_from_sub_in,
   input wire logic fwd_mgmt_in,
   input wire logic [15:0] fwd_len_in,
   output logic fwd_ready_out,
   output logic tx_valid_out,
   output logic [15:0] tx_len_out,
   output logic drop_out,
   input wire logic cpe_req_in,
   output logic cpe_grant_out,
   output logic cpe_deny_out,
   output logic privacy_en_out,
   output logic [2:0] us_priority_out
);
   mct_pkg::mct_state_t st_q;
   logic [7:0] cur_type_q, cur_len_q, rem_q, outer_q;
   logic in_cls_q;
   logic [23:0] acc_q;
   logic take, last, err_set, clr_q, ack_q;
   logic [31:0] val;
   logic [31:0] ctrl_q, max_ds_q, max_us_q, min_us_q, ts_q;
   logic [7:0] ucid_q, cpe_cfg_q, cls_id_q, cpe_cnt_q, cpe_lim;
   logic [2:0] prio_q;
   logic [15:0] burst_q;
   logic [127:0] mic_cm_q, mic_he_q;
   logic [7:0] cont_q [4];
   logic gate_q, ucid_ok_q, found_q, legacy_q, priv_q, cls_ok_q, err_q;
   logic mic_cm_ok_q, mic_he_ok_q, drop;
   mct_rate_if rate_bus ();

   assign cfg_ready_out = 1'b1;
   assign take = cfg_valid_in && cfg_ready_out;
   assign last = take && (st_q == mct_pkg::MCT_ST_VAL) && (rem_q == 8'h01);
   // first octet is the high one
   assign val = {acc_q, cfg_data_in};

   // ==========================================================
   // Setting parser
   // length drives every step
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || clr_q) begin
         st_q <= mct_pkg::MCT_ST_TYPE;
         cur_type_q <= 8'h00;
         cur_len_q <= 8'h00;
         rem_q <= 8'h00;
         acc_q <= 24'h000000;
      end else if (take) begin
         case (st_q)
            mct_pkg::MCT_ST_TYPE: begin
               cur_type_q <= cfg_data_in;
               st_q <= mct_pkg::MCT_ST_LEN;
            end
            mct_pkg::MCT_ST_LEN: begin
               cur_len_q <= cfg_data_in;
               rem_q <= cfg_data_in;
               acc_q <= 24'h000000;
               if (cfg_data_in == 8'h00 || (!in_cls_q && cur_type_q == `MCT_T_CLASS)) begin
                  st_q <= mct_pkg::MCT_ST_TYPE;
               end else begin
                  st_q <= mct_pkg::MCT_ST_VAL;
               end
            end
            mct_pkg::MCT_ST_VAL: begin
               rem_q <= rem_q - 8'h01;
               acc_q <= val[23:0];
               // Sub value cut short by its container end is abandoned
               if (rem_q == 8'h01 || (in_cls_q && outer_q == 8'h01)) begin
                  st_q <= mct_pkg::MCT_ST_TYPE;
               end
            end
            default: begin
               st_q <= mct_pkg::MCT_ST_TYPE;
            end
         endcase
      end
   end

   // Container octets left
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || clr_q) begin
         in_cls_q <= 1'b0;
         outer_q <= 8'h00;
      end else if (take && !in_cls_q && st_q == mct_pkg::MCT_ST_LEN &&
                   cur_type_q == `MCT_T_CLASS) begin
         in_cls_q <= (cfg_data_in != 8'h00);
         outer_q <= cfg_data_in;
      end else if (take && in_cls_q) begin
         outer_q <= outer_q - 8'h01;
         in_cls_q <= (outer_q != 8'h01);
      end
   end

   // ==========================================================
   // Top-level settings
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ucid_q <= 8'h00;
         ucid_ok_q <= 1'b0;
         gate_q <= 1'b1;
         cpe_cfg_q <= 8'h00;
         ts_q <= 32'h0000_0000;
      end else if (last && !in_cls_q) begin
         if (cur_type_q == `MCT_T_UCID && cur_len_q == 8'h01) begin
            ucid_q <= val[7:0];
            ucid_ok_q <= 1'b1;
         end
         if (cur_type_q == `MCT_T_GATE && cur_len_q == 8'h01) begin
            gate_q <= val[0];
         end
         if (cur_type_q == `MCT_T_CPE && cur_len_q == 8'h01) begin
            cpe_cfg_q <= val[7:0];
         end
         if (cur_type_q == `MCT_T_TS && cur_len_q == 8'h04) begin
            ts_q <= val;
         end
      end else if (clr_q) begin
         ucid_ok_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         mic_cm_q <= '0;
         mic_he_q <= '0;
         mic_cm_ok_q <= 1'b0;
         mic_he_ok_q <= 1'b0;
      end else if (take && st_q == mct_pkg::MCT_ST_VAL && !in_cls_q &&
                   cur_len_q == `MCT_L_MIC) begin
         if (cur_type_q == `MCT_T_MIC_CM) begin
            mic_cm_q <= {mic_cm_q[119:0], cfg_data_in};
            mic_cm_ok_q <= last;
         end
         if (cur_type_q == `MCT_T_MIC_HE) begin
            mic_he_q <= {mic_he_q[119:0], cfg_data_in};
            mic_he_ok_q <= last;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cont
         always_ff @(posedge sys_clk_in) begin
            if (rst_in || clr_q) begin
               cont_q[gi] <= 8'h00;
            end else if (take && !in_cls_q && st_q == mct_pkg::MCT_ST_LEN &&
                         cur_type_q == `MCT_T_US_CLS + 8'(gi) && cont_q[gi] != 8'hFF) begin
               cont_q[gi] <= cont_q[gi] + 8'h01;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Class sub-settings
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cls_id_q <= 8'h00;
         cls_ok_q <= 1'b0;
         max_ds_q <= 32'h0000_0000;
         max_us_q <= 32'h0000_0000;
         min_us_q <= 32'h0000_0000;
         prio_q <= 3'h0;
         burst_q <= 16'h0000;
         priv_q <= 1'b0;
      end else if (last && in_cls_q) begin
         if (cur_type_q == `MCT_S_ID && cur_len_q == 8'h01) begin
            cls_ok_q <= (val[7:0] >= `MCT_CLS_ID_MIN && val[7:0] <= `MCT_CLS_ID_MAX);
            cls_id_q <= val[7:0];
         end
         if (cur_type_q == `MCT_S_MAX_DS && cur_len_q == 8'h04) begin
            max_ds_q <= val;
         end
         if (cur_type_q == `MCT_S_MAX_US && cur_len_q == 8'h04) begin
            max_us_q <= val;
         end
         if (cur_type_q == `MCT_S_PRIO && cur_len_q == 8'h01 && val[7:0] <= `MCT_PRIO_MAX) begin
            prio_q <= val[2:0];
         end
         if (cur_type_q == `MCT_S_MIN_US && cur_len_q == 8'h04) begin
            min_us_q <= val;
         end
         if (cur_type_q == `MCT_S_BURST && cur_len_q == 8'h02) begin
            burst_q <= val[15:0];
         end
         if (cur_type_q == `MCT_S_PRIV && cur_len_q == 8'h01) begin
            priv_q <= val[0];
         end
      end
   end

   // Out-of-range values flagged, set beats clear
   assign err_set = last && in_cls_q && cur_len_q == 8'h01 &&
                    ((cur_type_q == `MCT_S_ID && (val[7:0] < `MCT_CLS_ID_MIN ||
                      val[7:0] > `MCT_CLS_ID_MAX)) ||
                     (cur_type_q == `MCT_S_PRIO && val[7:0] > `MCT_PRIO_MAX));
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         err_q <= 1'b0;
         legacy_q <= 1'b0;
      end else begin
         err_q <= err_set || (err_q && !clr_q);
         legacy_q <= (take && !in_cls_q && st_q == mct_pkg::MCT_ST_LEN &&
                      cur_type_q == `MCT_T_CLASS) || (legacy_q && !clr_q);
      end
   end

   // ==========================================================
   // Upstream channel search
   // match ends the listening phase
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         found_q <= 1'b0;
      end else begin
         found_q <= (ucd_valid_in && ucid_ok_q && ucd_chan_in == ucid_q) ||
                    (found_q && !clr_q);
      end
   end
   assign keep_listening_out = ucid_ok_q && !found_q;
   assign us_chan_out = ucid_q;
   assign privacy_en_out = priv_q;
   assign us_priority_out = prio_q;

   // ==========================================================
   // Forwarding gate and shaping
   // own management never gated
   assign drop = fwd_from_sub_in && !fwd_mgmt_in && !gate_q;
   assign rate_bus.en = ctrl_q[`MCT_CTRL_SHAPE];
   assign rate_bus.max_bps = max_us_q;
   assign rate_bus.len = fwd_len_in;
   assign rate_bus.take = fwd_valid_in && fwd_ready_out && !drop;
   // hold back, never discard for rate
   assign fwd_ready_out = drop || rate_bus.ok;

   mct_shaper #(.WIN_CYC(WIN_CYC)) u_shaper (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .rate(rate_bus.shp)
   );

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         tx_valid_out <= 1'b0;
         tx_len_out <= 16'h0000;
         drop_out <= 1'b0;
      end else begin
         tx_valid_out <= rate_bus.take;
         drop_out <= fwd_valid_in && drop;
         if (rate_bus.take) begin
            tx_len_out <= fwd_len_in;
         end
      end
   end

   // ==========================================================
   // Subscriber device admission
   // zero or absent means one
   always_comb begin
      cpe_lim = (cpe_cfg_q == 8'h00) ? 8'h01 : cpe_cfg_q;
      if (cpe_lim > HW_CPE_MAX) begin
         cpe_lim = HW_CPE_MAX;
      end
   end
   // Count clears only on reset, not on a new file
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cpe_cnt_q <= 8'h00;
         cpe_grant_out <= 1'b0;
         cpe_deny_out <= 1'b0;
      end else begin
         cpe_grant_out <= cpe_req_in && cpe_cnt_q < cpe_lim;
         cpe_deny_out <= cpe_req_in && cpe_cnt_q >= cpe_lim;
         if (cpe_req_in && cpe_cnt_q < cpe_lim) begin
            cpe_cnt_q <= cpe_cnt_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // Register slave, one wait cycle per access
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
         ctrl_q <= `MCT_CTRL_RST;
         clr_q <= 1'b0;
      end else begin
         ack_q <= (avs_read_in || avs_write_in) && !ack_q;
         clr_q <= avs_write_in && ack_q && avs_address_in == `MCT_R_CTRL &&
                  avs_byteenable_in[0] && avs_writedata_in[`MCT_CTRL_CLEAR];
         if (avs_write_in && ack_q && avs_address_in == `MCT_R_CTRL && avs_byteenable_in[0]) begin
            ctrl_q <= {31'h0000_0000, avs_writedata_in[`MCT_CTRL_SHAPE]};
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && !ack_q) begin
         case ({avs_address_in[6:2], 2'h0})
            `MCT_R_CTRL: avs_readdata_out <= ctrl_q;
            `MCT_R_STATUS: avs_readdata_out <= {23'h000000, mic_he_ok_q, mic_cm_ok_q, cls_ok_q,
               (burst_q == 16'h0000), err_q, legacy_q, found_q, ucid_ok_q, gate_q};
            `MCT_R_UCID: avs_readdata_out <= {24'h000000, ucid_q};
            `MCT_R_CPE: avs_readdata_out <= {8'h00, cpe_cnt_q, cpe_cfg_q, cpe_lim};
            `MCT_R_CLASS: avs_readdata_out <= {15'h0000, priv_q, 5'h00, prio_q, cls_id_q};
            `MCT_R_MAX_DS: avs_readdata_out <= max_ds_q;
            `MCT_R_MAX_US: avs_readdata_out <= max_us_q;
            `MCT_R_MIN_US: avs_readdata_out <= min_us_q;
            `MCT_R_BURST: avs_readdata_out <= {16'h0000, burst_q};
            `MCT_R_TS: avs_readdata_out <= ts_q;
            `MCT_R_CONT: avs_readdata_out <= {cont_q[3], cont_q[2], cont_q[1], cont_q[0]};
            `MCT_R_MIC_CM: avs_readdata_out <= mic_cm_q[127:96];
            `MCT_R_MIC_CM + 7'h04: avs_readdata_out <= mic_cm_q[95:64];
            `MCT_R_MIC_CM + 7'h08: avs_readdata_out <= mic_cm_q[63:32];
            `MCT_R_MIC_CM + 7'h0C: avs_readdata_out <= mic_cm_q[31:0];
            `MCT_R_MIC_HE: avs_readdata_out <= mic_he_q[127:96];
            `MCT_R_MIC_HE + 7'h04: avs_readdata_out <= mic_he_q[95:64];
            `MCT_R_MIC_HE + 7'h08: avs_readdata_out <= mic_he_q[63:32];
            `MCT_R_MIC_HE + 7'h0C: avs_readdata_out <= mic_he_q[31:0];
            default: avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   gate_drop_a: assert property (fwd_valid_in && drop |=> drop_out && !tx_valid_out)
      else $error("gated subscriber frame not dropped");
   mgmt_pass_a: assert property (fwd_valid_in && fwd_mgmt_in && fwd_ready_out |=>
      tx_valid_out && !drop_out)
      else $error("management frame not forwarded");
   listen_end_a: assert property (ucd_valid_in && ucid_ok_q && ucd_chan_in == ucid_q &&
      !clr_q |=> !keep_listening_out)
      else $error("still listening after channel match");
   cpe_floor_a: assert property (cpe_lim >= 8'h01 && cpe_lim <= HW_CPE_MAX)
      else $error("device limit out of range");
   cpe_cap_a: assert property (cpe_req_in && cpe_cnt_q >= cpe_lim |=>
      cpe_deny_out && !cpe_grant_out && $stable(cpe_cnt_q))
      else $error("device admitted above limit");
   class_range_a: assert property (last && in_cls_q && cur_type_q == `MCT_S_ID &&
      cur_len_q == 8'h01 && (val[7:0] == 8'h00 || val[7:0] > 8'h10) |=> !cls_ok_q && err_q)
      else $error("bad class identifier accepted");
   prio_hold_a: assert property (last && in_cls_q && cur_type_q == `MCT_S_PRIO &&
      val[7:0] > 8'h07 |=> $stable(prio_q))
      else $error("priority above seven stored");
   ts_order_a: assert property (last && !in_cls_q && cur_type_q == `MCT_T_TS &&
      cur_len_q == 8'h04 |=> ts_q == {$past(acc_q), $past(cfg_data_in)})
      else $error("timestamp octet order wrong");
   skip_a: assert property (take && st_q == mct_pkg::MCT_ST_VAL && rem_q == 8'h01 &&
      !(in_cls_q && outer_q == 8'h01) |=> st_q == mct_pkg::MCT_ST_TYPE)
      else $error("parser lost setting boundary");
   bus_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
      !avs_waitrequest_out)
      else $error("bus access not answered in one cycle");
   cover property (drop_out);
   cover property (cpe_deny_out);
   cover property (found_q && ucid_ok_q);
   cover property (cls_ok_q && legacy_q);
endmodule : mct_tlv_policy
`default_nettype wire

/* File: tb/mct_headend_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Headend side upstream rate policing
module mct_headend_model #(
   parameter int WIN_CYC = 64
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic tx_valid_in,
   input wire logic [15:0] tx_len_in,
   input wire logic [31:0] max_bps_in,
   output logic alarm_out
);
   int unsigned bits_q;
   int unsigned tick_q;
   // gate value never seen here
   // Windows not aligned with the modem, so two budgets are tolerated
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bits_q <= 0;
         tick_q <= 0;
         alarm_out <= 1'b0;
      end else begin
         tick_q <= (tick_q == WIN_CYC - 1) ? 0 : tick_q + 1;
         if (tick_q == WIN_CYC - 1) begin
            bits_q <= 0;
         end else if (tx_valid_in) begin
            bits_q <= bits_q + 8 * tx_len_in;
         end
         if (max_bps_in != 0 && bits_q > 2 * max_bps_in) begin
            alarm_out <= 1'b1;
         end
      end
   end
endmodule : mct_headend_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench for the setting decoder
module testbench;
   logic clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, cv = 1'b0, uv = 1'b0;
   logic fv = 1'b0, fs = 1'b0, fm = 1'b0, cr = 1'b0;
   logic [6:0] adr = 7'h00;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [7:0] cd = 8'h00, uc = 8'h00, uch;
   logic [15:0] fl = 16'h0000, tl;
   logic wq, keep, rdy, txv, drp, gr, dn, priv, alarm, cfr;
   logic [2:0] prio;
   int fails = 0, checks_done = 0, cyc = 0, n;
   mct_tlv_policy #(.WIN_CYC(64)) i_mct_tlv_policy (.sys_clk_in(clk), .rst_in(rst),
      .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
      .cfg_valid_in(cv), .cfg_data_in(cd), .cfg_ready_out(cfr), .ucd_valid_in(uv),
      .ucd_chan_in(uc), .us_chan_out(uch), .keep_listening_out(keep), .fwd_valid_in(fv),
      .fwd_from_sub_in(fs), .fwd_mgmt_in(fm), .fwd_len_in(fl), .fwd_ready_out(rdy),
      .tx_valid_out(txv), .tx_len_out(tl), .drop_out(drp), .cpe_req_in(cr),
      .cpe_grant_out(gr), .cpe_deny_out(dn), .privacy_en_out(priv), .us_priority_out(prio));
   mct_headend_model #(.WIN_CYC(64)) i_mct_headend_model (.sys_clk_in(clk), .rst_in(rst),
      .tx_valid_in(txv), .tx_len_in(tl), .max_bps_in(32'h0000_0100), .alarm_out(alarm));
   always #5 clk = ~clk;
   // ==========================================
   // Shared tasks
   task report_and_stop();
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd_s <= !w;
      wr_s <= w;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      q = rdat;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask : bus
   task oct(input logic [7:0] b);
      @(posedge clk);
      cv <= 1'b1;
      cd <= b;
   endtask : oct
   task tlv(input logic [7:0] t, input logic [7:0] l, input logic [31:0] v);
      oct(t);
      oct(l);
      for (int i = l - 1; i >= 0; i--) oct(v[8*i+:8]);
      @(posedge clk);
      cv <= 1'b0;
      @(negedge clk);
   endtask : tlv
   task integrity_check_code(input logic [7:0] t);
      oct(t);
      oct(8'h10);
      for (int i = 0; i < 16; i++) oct(t + 8'(i));
      @(posedge clk);
      cv <= 1'b0;
      @(negedge clk);
   endtask : integrity_check_code
   task pulse(input logic u, input logic [7:0] ch);
      @(posedge clk);
      uv <= u;
      cr <= !u;
      uc <= ch;
      @(posedge clk);
      uv <= 1'b0;
      cr <= 1'b0;
      @(negedge clk);
   endtask : pulse
   task fwd(input logic s, input logic m, input logic dr);
      @(posedge clk);
      fv <= 1'b1;
      fs <= s;
      fm <= m;
      fl <= 16'h0010;
      @(posedge clk);
      while (rdy !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      fv <= 1'b0;
      @(negedge clk);
      chk({31'h0, txv}, {31'h0, !dr});
      chk({31'h0, drp}, {31'h0, dr});
      if (!dr) chk({16'h0, tl}, 32'h0000_0010);
   endtask : fwd
   // ==========================================
   // Scenarios
   task t_reset();
      bus(1'b0, 7'h04, 32'h0);
      chk(q, 32'h0000_0021);
      chk({31'h0, cfr}, 32'h1);
      bus(1'b1, 7'h04, 32'h0);
      bus(1'b0, 7'h7C, 32'h0);
      chk(q, 32'h0);
   endtask : t_reset
   task t_chan();
      tlv(8'h02, 8'h01, 32'h05);
      pulse(1'b1, 8'h03);
      chk({24'h0, uch}, 32'h05);
      chk({31'h0, keep}, 32'h1);
      pulse(1'b1, 8'h05);
      chk({31'h0, keep}, 32'h0);
   endtask : t_chan
   task t_subs();
      tlv(8'h63, 8'h02, 32'hBEEF);
      tlv(8'h13, 8'h04, 32'hA1B2_C3D4);
      tlv(8'h12, 8'h01, 32'h00);
      bus(1'b0, 7'h24, 32'h0);
      chk(q, 32'hA1B2_C3D4);
      bus(1'b0, 7'h0C, 32'h0);
      chk({24'h0, q[7:0]}, 32'h01);
      pulse(1'b0, 8'h00);
      chk({30'h0, gr, dn}, 32'h2);
      pulse(1'b0, 8'h00);
      chk({30'h0, gr, dn}, 32'h1);
      integrity_check_code(8'h06);
      integrity_check_code(8'h07);
      tlv(8'h18, 8'h01, 32'h00);
      bus(1'b0, 7'h30, 32'h0);
      chk(q, 32'h0607_0809);
      bus(1'b0, 7'h40, 32'h0);
      chk(q, 32'h0708_090A);
      bus(1'b0, 7'h28, 32'h0);
      chk(q, 32'h0001_0000);
   endtask : t_subs
   task t_class();
      oct(8'h04);
      oct(8'h1F);
      tlv(8'h01, 8'h01, 32'h01);
      tlv(8'h02, 8'h04, 32'h0098_9680);
      tlv(8'h03, 8'h04, 32'h100);
      tlv(8'h04, 8'h01, 32'h07);
      tlv(8'h05, 8'h04, 32'h0000_FA00);
      tlv(8'h06, 8'h02, 32'h05EE);
      tlv(8'h07, 8'h01, 32'h01);
      chk({28'h0, priv, prio}, 32'hF);
      bus(1'b0, 7'h04, 32'h0);
      chk(q & 32'h68, 32'h48);
      bus(1'b0, 7'h18, 32'h0);
      chk(q, 32'h100);
      bus(1'b0, 7'h14, 32'h0);
      chk(q, 32'h0098_9680);
      bus(1'b0, 7'h1C, 32'h0);
      chk(q, 32'h0000_FA00);
      bus(1'b0, 7'h20, 32'h0);
      chk(q, 32'h0000_05EE);
      oct(8'h04);
      oct(8'h06);
      tlv(8'h01, 8'h01, 32'h00);
      tlv(8'h04, 8'h01, 32'h09);
      chk({28'h0, priv, prio}, 32'hF);
      bus(1'b0, 7'h04, 32'h0);
      chk(q & 32'h58, 32'h18);
      // Five frames so one window always overflows
      n = 0;
      repeat (5) fwd(1'b0, 1'b0, 1'b0);
      chk({31'h0, n != 0}, 32'h1);
   endtask : t_class
   task t_clear();
      bus(1'b1, 7'h00, 32'h0000_0002);
      bus(1'b0, 7'h00, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 7'h04, 32'h0);
      chk(q, 32'h0000_0180);
      bus(1'b0, 7'h0C, 32'h0);
      chk(q, 32'h0001_0001);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 7'h0C, 32'h0);
      chk(q, 32'h0000_0001);
   endtask : t_clear
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_chan();
      t_subs();
      t_class();
      tlv(8'h03, 8'h01, 32'h00);
      fwd(1'b1, 1'b0, 1'b1);
      fwd(1'b1, 1'b1, 1'b0);
      chk({31'h0, alarm}, 32'h0);
      t_clear();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
